// [tmr_pkg.sv]
// constants and carriers for the 18-bit timer/counter control block
// assumes one fast clock; slow clock arrives as a one-cycle enable
`default_nettype none
package tmr_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_MATCH_LOW = 8'h10;
  localparam logic [7:0] IDX_MATCH_MID = 8'h11;
  localparam logic [7:0] IDX_MATCH_TOP = 8'h12;
  localparam logic [7:0] IDX_GATE = 8'h13;
  localparam logic [7:0] IDX_CTRL = 8'h14;
  localparam logic [7:0] IDX_CTRL2 = 8'h15;
  localparam logic [7:0] IDX_STATUS = 8'h16;

  localparam int MATCH_W = 18;
  localparam int TOP_BITS = 2;

  // count_control layout
  typedef struct packed {
    logic flag_ctl;
    logic [1:0] run;
    logic [2:0] clk_sel;
    logic [1:0] mode;
  } tmr_ctrl_t;
  localparam logic [7:0] CTRL_RESET = 8'h88;

  // count_control_second layout
  typedef struct packed {
    logic edge_both;
    logic [1:0] gate_src;
    logic gate_irq_edge;
    logic [1:0] gate_clk;
    logic ext_out;
    logic zero;
  } tmr_ctrl2_t;
  localparam logic [7:0] CTRL2_RESET = 8'h00;

  localparam logic [7:0] GATE_RESET = 8'h00;
  localparam int GATE_HIGH_LSB = 4;
  localparam int GATE_LOW_LSB = 0;
  localparam logic [4:0] GATE_BASE = 5'h10;

  localparam int ST_GATE_BIT = 7;
  localparam int ST_OVF_BIT = 6;

  localparam logic [1:0] RUN_STOP = 2'h0;
  localparam logic [1:0] RUN_START = 2'h2;

  localparam logic [2:0] CK_FC = 3'h0;
  localparam logic [2:0] CK_FS = 3'h1;
  localparam logic [2:0] CK_D23 = 3'h2;
  localparam logic [2:0] CK_D13 = 3'h3;
  localparam logic [2:0] CK_D11 = 3'h4;
  localparam logic [2:0] CK_D7 = 3'h5;
  localparam logic [2:0] CK_D3 = 3'h6;
  localparam logic [2:0] CK_EXT = 3'h7;

  localparam logic [1:0] MD_TIMER = 2'h0;
  localparam logic [1:0] MD_RSVD = 2'h1;
  localparam logic [1:0] MD_PULSE = 2'h2;
  localparam logic [1:0] MD_FREQ = 2'h3;

  localparam logic [1:0] GCK_D12 = 2'h0;
  localparam logic [1:0] GCK_D13 = 2'h1;
  localparam logic [1:0] GCK_D14 = 2'h2;

  localparam int FC_DIV_W = 23;
  localparam int FS_DIV_W = 15;

  // divided-clock enable pulses, one cycle each
  typedef struct packed {
    logic fc_d3;
    logic fc_d7;
    logic fc_d11;
    logic fc_d12;
    logic fc_d13;
    logic fc_d14;
    logic fc_d23;
    logic fs_d3;
    logic fs_d4;
    logic fs_d5;
    logic fs_d6;
    logic fs_d15;
  } tmr_ticks_t;
endpackage : tmr_pkg
`default_nettype wire

// [tmr_presc.sv]
// free-running dividers giving one-cycle enables of fast and slow clock
// assumes slow_tick_i is a one-cycle pulse per slow clock period
`default_nettype none
module tmr_presc
  import tmr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_tick_i,
  output tmr_ticks_t ticks_o
);
  logic [FC_DIV_W-1:0] fc_cnt_reg;
  logic [FS_DIV_W-1:0] fs_cnt_reg;

  // never cleared by the timer, so divided ticks keep their phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fc_cnt_reg <= '0;
    end else begin
      fc_cnt_reg <= fc_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fs_cnt_reg <= '0;
    end else if (slow_tick_i) begin
      fs_cnt_reg <= fs_cnt_reg + 1'b1;
    end
  end

  always_comb begin
    ticks_o.fc_d3 = &fc_cnt_reg[2:0];
    ticks_o.fc_d7 = &fc_cnt_reg[6:0];
    ticks_o.fc_d11 = &fc_cnt_reg[10:0];
    ticks_o.fc_d12 = &fc_cnt_reg[11:0];
    ticks_o.fc_d13 = &fc_cnt_reg[12:0];
    ticks_o.fc_d14 = &fc_cnt_reg[13:0];
    ticks_o.fc_d23 = &fc_cnt_reg[22:0];
    ticks_o.fs_d3 = slow_tick_i & (&fs_cnt_reg[2:0]);
    ticks_o.fs_d4 = slow_tick_i & (&fs_cnt_reg[3:0]);
    ticks_o.fs_d5 = slow_tick_i & (&fs_cnt_reg[4:0]);
    ticks_o.fs_d6 = slow_tick_i & (&fs_cnt_reg[5:0]);
    ticks_o.fs_d15 = slow_tick_i & (&fs_cnt_reg[14:0]);
  end
endmodule : tmr_presc
`default_nettype wire

// [tmr_gate.sv]
// internal window gate pulse: high then low, counted in gate ticks
// assumes tick_i is a one-cycle enable of the gate source clock
`default_nettype none
module tmr_gate
  import tmr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic tick_i,
  input wire logic [3:0] high_set_i,
  input wire logic [3:0] low_set_i,
  output logic gate_o
);
  typedef enum logic [1:0] {GT_IDLE, GT_HIGH, GT_LOW} tmr_gstate_t;
  tmr_gstate_t state_reg;
  logic [4:0] cnt_reg;
  logic [4:0] high_len;
  logic [4:0] low_len;

  assign high_len = GATE_BASE - {1'b0, high_set_i};
  assign low_len = GATE_BASE - {1'b0, low_set_i};

  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      state_reg <= GT_IDLE;
      cnt_reg <= '0;
      gate_o <= 1'b0;
    end else begin
      case (state_reg)
        GT_IDLE: begin
          state_reg <= GT_HIGH;
          cnt_reg <= '0;
          gate_o <= 1'b1;
        end
        GT_HIGH: begin
          if (tick_i) begin
            if (cnt_reg == high_len - 5'h01) begin
              state_reg <= GT_LOW;
              cnt_reg <= '0;
              gate_o <= 1'b0;
            end else begin
              cnt_reg <= cnt_reg + 5'h01;
            end
          end
        end
        GT_LOW: begin
          if (tick_i) begin
            if (cnt_reg == low_len - 5'h01) begin
              state_reg <= GT_HIGH;
              cnt_reg <= '0;
              gate_o <= 1'b1;
            end else begin
              cnt_reg <= cnt_reg + 5'h01;
            end
          end
        end
        default: begin
          state_reg <= GT_IDLE;
          cnt_reg <= '0;
          gate_o <= 1'b0;
        end
      endcase
    end
  end
endmodule : tmr_gate
`default_nettype wire

// [tmr_top.sv]
// 18-bit up-counting timer/counter: registers, source select, counter
// assumes an Avalon-MM master with word addressing and waitrequest
//
// Local design decision: the Avalon-MM register port.
`default_nettype none

// Function
// - run 00 stops and clears; 10 starts
// - clock code 111 counts external pin edges
// - codes 000-110 pick fast, slow, divided clocks
// - mode 00 timer, 10 pulse, 11 frequency
// - low or mid write blocks matching until top
// - match value address reads live counter
// - top match byte bits 7..2 read zero
// - gate high lasts sixteen minus high setting
// - gate low lasts sixteen minus low setting
// - control pair, 18-bit match, gate register
// - gate clock codes 00-10 valid, 11 reserved
// - timer match raises interrupt, clears, continues
module tmr_top
  import tmr_pkg::*;
#(
  parameter int COUNT_W = MATCH_W
)
(
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic SLOW_TICK_I,
  input wire logic SLOW_MODE_I,
  input wire logic DIVIDER_TAP_SELECT_I,
  input wire logic EXTERNAL_COUNT_INPUT_I,
  output logic COMPARE_MATCH_IRQ_O,
  output logic GATE_O
);
  if (COUNT_W != MATCH_W) begin : g_width_check
    $error("tmr_top: counter width must equal the match width");
  end

  tmr_ctrl_t ctrl_reg;
  tmr_ctrl2_t ctrl2_reg;
  logic [7:0] gate_reg;
  logic [COUNT_W-1:0] match_reg;
  logic [COUNT_W-1:0] cnt_reg;
  logic [COUNT_W-1:0] cnt_plus;
  logic inhibit_reg;
  logic ovf_reg;
  logic ext_prev_reg;
  logic gate_prev_reg;
  logic gate_lvl;
  logic ext_fall;
  logic ext_rise;
  logic ext_edge;
  logic use_fs;
  logic cnt_tick;
  logic gate_tick;
  logic running;
  logic stop_clear;
  logic wr_ok;
  logic rd_take;
  logic [7:0] rd_byte;
  tmr_ticks_t ticks;

  // bus handshake: one wait cycle, then the access completes
  assign wr_ok = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0];
  assign rd_take = AVS_READ_I && AVS_WAITREQUEST_O;

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
    end else if ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O) begin
      AVS_WAITREQUEST_O <= 1'b0;
    end else begin
      AVS_WAITREQUEST_O <= 1'b1;
    end
  end

  // register writes
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      ctrl_reg <= tmr_ctrl_t'(CTRL_RESET);
    end else if (wr_ok && AVS_ADDRESS_I == IDX_CTRL) begin
      ctrl_reg <= tmr_ctrl_t'(AVS_WRITEDATA_I[7:0]);
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      ctrl2_reg <= tmr_ctrl2_t'(CTRL2_RESET);
    end else if (wr_ok && AVS_ADDRESS_I == IDX_CTRL2) begin
      ctrl2_reg <= tmr_ctrl2_t'({AVS_WRITEDATA_I[7:1], 1'b0});
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      gate_reg <= GATE_RESET;
    end else if (wr_ok && AVS_ADDRESS_I == IDX_GATE) begin
      gate_reg <= AVS_WRITEDATA_I[7:0];
    end
  end

  // match value written bytewise, never read back
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      match_reg <= '0;
    end else if (wr_ok) begin
      case (AVS_ADDRESS_I)
        IDX_MATCH_LOW: match_reg[7:0] <= AVS_WRITEDATA_I[7:0];
        IDX_MATCH_MID: match_reg[15:8] <= AVS_WRITEDATA_I[7:0];
        IDX_MATCH_TOP: begin
          match_reg[COUNT_W-1:16] <=
            AVS_WRITEDATA_I[TOP_BITS-1:0];
        end
        default: match_reg <= match_reg;
      endcase
    end
  end

  // a half-written match value must not fire on a stale upper part
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      inhibit_reg <= 1'b0;
    end else if (wr_ok && AVS_ADDRESS_I == IDX_MATCH_TOP) begin
      inhibit_reg <= 1'b0;
    end else if (wr_ok && (AVS_ADDRESS_I == IDX_MATCH_LOW ||
                           AVS_ADDRESS_I == IDX_MATCH_MID)) begin
      inhibit_reg <= 1'b1;
    end
  end

  // count source select
  assign use_fs = SLOW_MODE_I || DIVIDER_TAP_SELECT_I;
  assign ext_fall = ext_prev_reg && !EXTERNAL_COUNT_INPUT_I;
  assign ext_rise = !ext_prev_reg && EXTERNAL_COUNT_INPUT_I;
  assign ext_edge = ext_fall || (ctrl2_reg.edge_both && ext_rise);

  always_comb begin
    case (ctrl_reg.clk_sel)
      CK_FC: cnt_tick = 1'b1;
      CK_FS: cnt_tick = SLOW_TICK_I;
      CK_D23: cnt_tick = use_fs ? ticks.fs_d15 : ticks.fc_d23;
      CK_D13: cnt_tick = use_fs ? ticks.fs_d5 : ticks.fc_d13;
      CK_D11: cnt_tick = use_fs ? ticks.fs_d3 : ticks.fc_d11;
      CK_D7: cnt_tick = ticks.fc_d7;
      CK_D3: cnt_tick = ticks.fc_d3;
      CK_EXT: cnt_tick = ext_edge;
      default: cnt_tick = 1'b0;
    endcase
  end

  // gate source; code 11 gives no tick, so the gate just holds
  always_comb begin
    case (ctrl2_reg.gate_clk)
      GCK_D12: gate_tick = use_fs ? ticks.fs_d4 : ticks.fc_d12;
      GCK_D13: gate_tick = use_fs ? ticks.fs_d5 : ticks.fc_d13;
      GCK_D14: gate_tick = use_fs ? ticks.fs_d6 : ticks.fc_d14;
      default: gate_tick = 1'b0;
    endcase
  end

  // reserved run or mode codes never count
  assign running = ctrl_reg.run == RUN_START &&
                   ctrl_reg.mode != MD_RSVD;
  assign stop_clear = ctrl_reg.run == RUN_STOP;
  assign cnt_plus = cnt_reg + 1'b1;

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      ext_prev_reg <= 1'b0;
      gate_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= EXTERNAL_COUNT_INPUT_I;
      gate_prev_reg <= gate_lvl;
    end
  end

  // up-counter per mode
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I || stop_clear) begin
      cnt_reg <= '0;
    end else if (running) begin
      case (ctrl_reg.mode)
        MD_TIMER: begin
          if (cnt_tick) begin
            if (!inhibit_reg && cnt_plus == match_reg) begin
              cnt_reg <= '0;
            end else begin
              cnt_reg <= cnt_plus;
            end
          end
        end
        MD_PULSE: begin
          if (ext_rise) begin
            cnt_reg <= '0;
          end else if (EXTERNAL_COUNT_INPUT_I && cnt_tick) begin
            cnt_reg <= cnt_plus;
          end
        end
        MD_FREQ: begin
          if (gate_lvl && !gate_prev_reg) begin
            cnt_reg <= '0;
          end else if (gate_lvl && ext_edge) begin
            cnt_reg <= cnt_plus;
          end
        end
        default: cnt_reg <= cnt_reg;
      endcase
    end
  end

  // overflow: counter wrapped through all ones
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I || stop_clear) begin
      ovf_reg <= 1'b0;
    end else if (running && cnt_tick && (&cnt_reg)) begin
      ovf_reg <= 1'b1;
    end
  end

  // interrupt pulse: match, end of pulse, or end of window
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I || !running) begin
      COMPARE_MATCH_IRQ_O <= 1'b0;
    end else begin
      case (ctrl_reg.mode)
        MD_TIMER: begin
          COMPARE_MATCH_IRQ_O <= cnt_tick && !inhibit_reg &&
                                 cnt_plus == match_reg;
        end
        MD_PULSE: COMPARE_MATCH_IRQ_O <= ext_fall;
        MD_FREQ: COMPARE_MATCH_IRQ_O <= !gate_lvl && gate_prev_reg;
        default: COMPARE_MATCH_IRQ_O <= 1'b0;
      endcase
    end
  end

  // read mux; match addresses return the live counter
  always_comb begin
    case (AVS_ADDRESS_I)
      IDX_MATCH_LOW: rd_byte = cnt_reg[7:0];
      IDX_MATCH_MID: rd_byte = cnt_reg[15:8];
      IDX_MATCH_TOP: begin
        rd_byte = {6'h00, cnt_reg[COUNT_W-1:16]};
      end
      IDX_GATE: rd_byte = gate_reg;
      IDX_CTRL: rd_byte = ctrl_reg;
      IDX_CTRL2: rd_byte = ctrl2_reg;
      IDX_STATUS: begin
        rd_byte = 8'h00;
        rd_byte[ST_GATE_BIT] = gate_lvl;
        rd_byte[ST_OVF_BIT] = ovf_reg;
      end
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      AVS_READDATA_O <= 32'h0000_0000;
    end else if (rd_take) begin
      AVS_READDATA_O <= {24'h00_0000, rd_byte};
    end
  end

  tmr_presc u_presc (
    .clk_i(MCLK_I),
    .rst_i(SYS_RST_I),
    .slow_tick_i(SLOW_TICK_I),
    .ticks_o(ticks)
  );

  // gate runs only while the counter runs
  tmr_gate u_gate (
    .clk_i(MCLK_I),
    .rst_i(SYS_RST_I),
    .en_i(running),
    .tick_i(gate_tick),
    .high_set_i(gate_reg[GATE_HIGH_LSB+:4]),
    .low_set_i(gate_reg[GATE_LOW_LSB+:4]),
    .gate_o(gate_lvl)
  );

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      GATE_O <= 1'b0;
    end else begin
      GATE_O <= gate_lvl;
    end
  end
endmodule : tmr_top
`default_nettype wire

// [tmr_top_asserts.sv]
// checker for tmr_top: bus handshake, match gating, quiet outputs
// assumes it is bound to tmr_top and sees only its ports
`default_nettype none
module tmr_top_chk
  import tmr_pkg::*;
#(
  parameter int COUNT_W = MATCH_W
)
(
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic COMPARE_MATCH_IRQ_O,
  input wire logic GATE_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);
  tmr_ctrl_t ctrl_w;
  logic wr_ok;
  logic [1:0] run_reg;
  logic [1:0] mode_reg;
  logic inhibit_reg;
  logic [2:0] stop_reg;
  assign ctrl_w = tmr_ctrl_t'(AVS_WRITEDATA_I[7:0]);
  assign wr_ok = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0];
  // shadow of run and mode, taken at the edge a write lands
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      run_reg <= RUN_STOP;
      mode_reg <= MD_TIMER;
    end else if (wr_ok && AVS_ADDRESS_I == IDX_CTRL) begin
      run_reg <= ctrl_w.run;
      mode_reg <= ctrl_w.mode;
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I || (wr_ok && AVS_ADDRESS_I == IDX_MATCH_TOP))
      inhibit_reg <= 1'b0;
    else if (wr_ok && AVS_ADDRESS_I inside {IDX_MATCH_LOW, IDX_MATCH_MID})
      inhibit_reg <= 1'b1;
  end
  // margin of a few cycles: an edge detector may still flush after stop
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I)
      stop_reg <= 3'h7;
    else if (run_reg == RUN_START)
      stop_reg <= 3'h0;
    else if (stop_reg != 3'h7)
      stop_reg <= stop_reg + 3'h1;
  end
  sequence s_req_open;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
  endsequence
  sequence s_read_at(logic [7:0] idx);
    s_req_open ##0 (AVS_READ_I && AVS_ADDRESS_I == idx);
  endsequence
  a_wait_one_cycle:
    assert property (s_req_open |=> !AVS_WAITREQUEST_O)
    else $error("waitrequest did not fall one cycle after a request");
  a_wait_short:
    assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("waitrequest stayed low for more than one cycle");
  a_top_bits_zero:
    assert property (s_read_at(IDX_MATCH_TOP) |=> AVS_READDATA_O[31:2] == 0)
    else $error("top match byte read with upper bits set");
  a_read_live_zero:
    assert property ((run_reg == RUN_STOP && $past(run_reg) == RUN_STOP)
      ##0 s_read_at(IDX_MATCH_LOW) |=> AVS_READDATA_O == 32'h0000_0000)
    else $error("stopped counter did not read as zero");
  a_stop_no_irq:
    assert property (stop_reg >= 3'h4 |-> !COMPARE_MATCH_IRQ_O)
    else $error("match pulse while counter stopped");
  a_rsvd_mode_quiet:
    assert property ((mode_reg == MD_RSVD && $past(mode_reg) == MD_RSVD)
      |-> !COMPARE_MATCH_IRQ_O)
    else $error("match pulse in reserved mode");
  a_inhibit_quiet:
    assert property (inhibit_reg && $past(inhibit_reg)
      |-> !COMPARE_MATCH_IRQ_O)
    else $error("match pulse before top byte was written");
  a_gate_idle_low:
    assert property (stop_reg == 3'h7 |-> !GATE_O)
    else $error("gate high while counter stopped");
endmodule : tmr_top_chk

bind tmr_top tmr_top_chk #(.COUNT_W(COUNT_W)) u_chk (.MCLK_I, .SYS_RST_I,
  .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I, .AVS_WRITEDATA_I,
  .AVS_BYTEENABLE_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O,
  .COMPARE_MATCH_IRQ_O, .GATE_O);
`default_nettype wire

// [tmr_pin_model.sv]
// far side model: slow clock enable and external count pin
// assumes one fast clock; the pin moves only right after a clock edge
`default_nettype none
module tmr_pin_model #(
  parameter int SLOW_PER = 4
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [3:0] edges_i,
  output logic slow_tick_o,
  output logic pin_o,
  output logic busy_o
);
  int div_reg;
  logic [4:0] left_reg;
  logic ph_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i || div_reg == SLOW_PER - 1)
      div_reg <= 0;
    else
      div_reg <= div_reg + 1;
  end
  assign slow_tick_o = (div_reg == 0);
  // pin idles high so every falling edge is a deliberate count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o <= 1'b1;
      left_reg <= 5'h00;
      ph_reg <= 1'b0;
    end else if (go_i) begin
      left_reg <= {edges_i, 1'b0};
    end else if (left_reg != 5'h00) begin
      ph_reg <= !ph_reg;
      if (ph_reg) begin
        pin_o <= !pin_o;
        left_reg <= left_reg - 5'h01;
      end
    end
  end
  assign busy_o = (left_reg != 5'h00);
endmodule : tmr_pin_model
`default_nettype wire

// [test_timer18_control_setup.sv]
// self-checking bench for tmr_top: registers, clock select, gate, match
// assumes the bound checker and the pin model on the far side
`default_nettype none
module test_timer18_control_setup import tmr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SP = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] be = 4'h0;
  logic slow = 1'b0;
  logic tap = 1'b0;
  logic go = 1'b0;
  logic [3:0] edges = 4'h0;
  logic [31:0] rdat;
  logic wreq, irq, gate, tick, pin, busy;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [15:0] rnd = 16'h9be5;
  initial begin
    forever #10 clk = ~clk;
  end
  tmr_top #(.COUNT_W(MATCH_W)) dut (.MCLK_I(clk), .SYS_RST_I(rst),
    .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wreq), .SLOW_TICK_I(tick), .SLOW_MODE_I(slow),
    .DIVIDER_TAP_SELECT_I(tap), .EXTERNAL_COUNT_INPUT_I(pin),
    .COMPARE_MATCH_IRQ_O(irq), .GATE_O(gate));
  tmr_pin_model #(.SLOW_PER(SP)) model (.clk_i(clk), .rst_i(rst), .go_i(go),
    .edges_i(edges), .slow_tick_o(tick), .pin_o(pin), .busy_o(busy));
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  function automatic int exp_period(input logic [2:0] ck, input logic sl,
      input int m);
    case (ck)
      CK_FS: return m * SP;
      CK_D13: return sl ? m * 32 * SP : m * 8192;
      CK_D11: return m * 2048;
      CK_D7: return m * 128;
      CK_D3: return m * 8;
      default: return m;
    endcase
  endfunction : exp_period
  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_data
  task automatic check_cycles(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_cycles
  // holds the request until waitrequest is sampled low
  task automatic bus_op(input logic w, input logic [7:0] a,
      input logic [7:0] d, input logic [3:0] b, output logic [31:0] q);
    @(posedge clk);
    adr <= a;
    wdat <= {24'h00_0000, d};
    be <= b;
    wr <= w;
    rd <= !w;
    // no local limit: only the bench timeout ends a stuck access
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus_op
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus_op(1'b1, a, d, 4'h1, q);
  endtask : wr8
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus_op(1'b0, a, 8'h00, 4'h1, q);
    check_data(q, exp);
  endtask : rd_chk
  // plain byte writes only, never read back and modified
  task automatic set_match(input logic [17:0] m);
    wr8(IDX_MATCH_LOW, m[7:0]);
    wr8(IDX_MATCH_MID, m[15:8]);
    wr8(IDX_MATCH_TOP, {6'h00, m[17:16]});
  endtask : set_match
  // edges until the watched output equals lvl, lim when it never does
  task automatic wait_for(input int sel, input logic lvl, input int lim,
      output int n);
    logic s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      s = (sel == 0) ? irq : (sel == 1) ? gate : busy;
    end while (s !== lvl && n < lim);
  endtask : wait_for
  task automatic pulse_pin(input logic [3:0] e);
    edges <= e;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask : pulse_pin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    logic [31:0] q;
    int n;
    int m;
    int k;
    logic [3:0] h;
    logic [3:0] l;
    logic [2:0] cks [7];
    logic [7:0] bad [2];
    cks = '{CK_FC, CK_FS, CK_D13, CK_D11, CK_D7, CK_D3, CK_D13};
    bad = '{8'h59, 8'h78};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd_chk(IDX_CTRL, {24'h00_0000, CTRL_RESET});
    rd_chk(IDX_GATE, 32'h0000_0000);
    wr8(IDX_MATCH_TOP, 8'hff);
    rd_chk(IDX_MATCH_TOP, 32'h0000_0000);
    bus_op(1'b1, 8'h20, 8'h5a, 4'h1, q);
    rd_chk(8'h20, 32'h0000_0000);
    wr8(IDX_CTRL2, 8'h01);
    rd_chk(IDX_CTRL2, 32'h0000_0000);
    bus_op(1'b1, IDX_GATE, 8'h5a, 4'h0, q);
    rd_chk(IDX_GATE, 32'h0000_0000);
    rnd = lfsr(rnd);
    h = rnd[7:4] | 4'h8;
    l = rnd[3:0] | 4'h8;
    wr8(IDX_GATE, {h, l});
    rd_chk(IDX_GATE, {24'h00_0000, h, l});
    for (int i = 0; i < 7; i++) begin
      rnd = lfsr(rnd);
      m = (i == 0) ? 257 : (i == 1) ? 2 + rnd[3:0] : 2;
      wr8(IDX_CTRL, 8'h00);
      slow <= (i == 0 || i == 6);
      set_match(m[17:0]);
      wr8(IDX_CTRL, {1'b0, RUN_START, cks[i], MD_TIMER});
      n = exp_period(cks[i], i == 0 || i == 6, m);
      wait_for(0, 1'b1, 2 * n + 99, k);
      wait_for(0, 1'b1, 2 * n + 99, k);
      check_cycles(k, n);
    end
    wr8(IDX_CTRL, 8'h00);
    slow <= 1'b0;
    set_match(18'h0_0004);
    wr8(IDX_CTRL, {1'b0, RUN_START, CK_D3, MD_TIMER});
    wr8(IDX_MATCH_LOW, 8'hff);
    @(posedge clk);
    wait_for(0, 1'b1, 80, n);
    check_cycles(n, 80);
    wr8(IDX_MATCH_TOP, 8'h00);
    wait_for(0, 1'b1, 4200, n);
    wait_for(0, 1'b1, 4200, n);
    check_cycles(n, 255 * 8);
    foreach (bad[j]) begin
      wr8(IDX_CTRL, 8'h00);
      rd_chk(IDX_STATUS, 32'h0000_0000);
      rd_chk(IDX_MATCH_LOW, 32'h0000_0000);
      wr8(IDX_CTRL, bad[j]);
      wait_for(0, 1'b1, 40, n);
      check_cycles(n, 40);
      rd_chk(IDX_MATCH_LOW, 32'h0000_0000);
    end
    wr8(IDX_CTRL, 8'h00);
    set_match(18'h0_0010);
    wr8(IDX_CTRL, {1'b0, RUN_START, CK_EXT, MD_TIMER});
    rnd = lfsr(rnd);
    pulse_pin({1'b0, rnd[2:0] | 3'h1});
    wait_for(2, 1'b0, 99, n);
    rd_chk(IDX_MATCH_LOW, {29'h0, rnd[2:0] | 3'h1});
    wr8(IDX_CTRL, 8'h00);
    wr8(IDX_CTRL, {1'b0, RUN_START, CK_FC, MD_PULSE});
    pulse_pin(4'h1);
    wait_for(0, 1'b1, 40, n);
    check_cycles(n < 40, 1);
    tap <= 1'b1;
    for (int g = 0; g < 3; g++) begin
      wr8(IDX_CTRL, 8'h00);
      wr8(IDX_CTRL2, {4'h0, g[1:0], 2'h0});
      wr8(IDX_CTRL, {1'b0, RUN_START, CK_EXT, MD_FREQ});
      n = (16 << g) * SP;
      // first high after enable is cut short by the free tick phase
      wait_for(1, 1'b1, 20 * n, k);
      wait_for(1, 1'b0, 20 * n, k);
      wait_for(1, 1'b1, 20 * n, k);
      check_cycles(k, (16 - l) * n);
      wait_for(1, 1'b0, 20 * n, k);
      check_cycles(k, (16 - h) * n);
    end
    wr8(IDX_CTRL, 8'h00);
    wrap_up();
  end
endmodule : test_timer18_control_setup
`default_nettype wire
